// ==== inc/stcr_pkg.sv ====
// shared constants and types for the target completion reporter
package stcr_pkg;

	// -----------------------------------------------------------------
	// report codes
	// -----------------------------------------------------------------
	localparam logic [7:0] CODE_BUS_RESET    = 8'h01;
	localparam logic [7:0] CODE_TIMEOUT      = 8'h2c;
	localparam logic [7:0] CODE_TIMEOUT_MSG  = 8'h20;
	localparam logic [7:0] CODE_ATN          = 8'h42;
	localparam logic [7:0] CODE_ATN_RX       = 8'h43;
	localparam logic [7:0] CODE_DONE         = 8'h60;
	localparam logic [7:0] CODE_DONE_ATN     = 8'h61;
	localparam logic [7:0] CODE_DONE_ATN_RX  = 8'h62;
	localparam logic [7:0] CODE_NO_COUNT     = 8'h65;

	// -----------------------------------------------------------------
	// step values
	// -----------------------------------------------------------------
	localparam logic [7:0] STEP_PRE          = 8'h00;
	localparam logic [7:0] STEP_FIRST        = 8'h01;
	localparam logic [7:0] STEP_MSGIN        = 8'h02;
	localparam logic [7:0] STEP_CLOSE_AFTER  = 8'h03;
	localparam logic [7:0] STEP_XFER_AFTER   = 8'h02;
	localparam logic [7:0] STEP_ONE          = 8'h01;
	localparam logic [7:0] STEP_NO_COUNT     = 8'h01;

	localparam logic [7:0] MSG_COUNT_EMPTY   = 8'h00;

	// synchroniser width: bus reset and attention
	localparam int         SYNC_WIDTH        = 2;
	localparam int         SYNC_BUS_RESET    = 0;
	localparam int         SYNC_ATN          = 1;

	// -----------------------------------------------------------------
	// enumerations and carriers
	// -----------------------------------------------------------------
	typedef enum logic [1:0] {
		CMD_CLOSE   = 2'h0,
		CMD_LINK    = 2'h1,
		CMD_RELEASE = 2'h2,
		CMD_SEND    = 2'h3
	} stcr_cmd_kind_type;

	typedef enum logic [1:0] {
		PH_STATUS = 2'h0,
		PH_MSGIN  = 2'h1,
		PH_MSGOUT = 2'h2
	} stcr_phase_type;

	typedef struct packed {
		stcr_cmd_kind_type kind;
		logic              auto_rx;
	} stcr_cmd_type;

	typedef struct packed {
		logic [7:0] code;
		logic [7:0] step;
	} stcr_report_type;

endpackage : stcr_pkg

// ==== core/stcr_sync.sv ====
// two-stage synchroniser for the bus-side levels
`timescale 1ns/1ps
module stcr_sync
	import stcr_pkg::*;
(
	input  wire logic                  clock_i,
	input  wire logic                  rst_i,
	input  wire logic [SYNC_WIDTH-1:0] async_i,
	output logic      [SYNC_WIDTH-1:0] sync_o
);

	// -----------------------------------------------------------------
	// per-bit flop pair; the first stage feeds only the second
	// -----------------------------------------------------------------
	logic [SYNC_WIDTH-1:0] meta;

	for (genvar b = 0; b < SYNC_WIDTH; b++) begin : g_bit
		always_ff @(posedge clock_i or posedge rst_i) begin
			if (rst_i) begin
				meta[b]   <= 1'b0;
				sync_o[b] <= 1'b0;
			end else begin
				meta[b]   <= async_i[b];
				sync_o[b] <= meta[b];
			end
		end
	end

endmodule : stcr_sync

// ==== core/stcr_report.sv ====
// report holder: keeps one code and step until the host takes it
`timescale 1ns/1ps
module stcr_report
	import stcr_pkg::*;
(
	input  wire logic            clock_i,
	input  wire logic            rst_i,
	input  wire logic            load_i,
	input  stcr_pkg::stcr_report_type data_i,
	input  wire logic            take_i,
	output logic                 valid_o,
	output stcr_pkg::stcr_report_type data_o
);

	logic            next_valid;
	stcr_report_type next_data;

	// -----------------------------------------------------------------
	// a load in the take cycle wins, so no report is lost
	// -----------------------------------------------------------------
	always_comb begin
		next_valid = valid_o;
		next_data  = data_o;
		if (take_i) begin
			next_valid = 1'b0;
		end
		if (load_i) begin
			next_valid = 1'b1;
			next_data  = data_i;
		end
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			valid_o <= 1'b0;
			data_o  <= '0;
		end else begin
			valid_o <= next_valid;
			data_o  <= next_data;
		end
	end

endmodule : stcr_report

// ==== core/stcr_core.sv ====
// completion and exception reporter for four target sequence commands
// -----------------------------------------------------------------
// Contract
// - close commands: bus reset steps 00/01/02
// - close commands: reset after message-in, step 03
// - close commands: status timeout gives 2Ch/01h
// - close commands: message-in timeout gives 20h/02h
// - attention without auto receive gives 42h, or 61h at a linked or send end
// - attention with auto receive: take message, 43h, or 62h at a linked or send end
// - close commands complete with 60h/03h
// - linked close: attention after message-in gives 61h or 62h, 03h
// - reset or timeout ends command at once
// - release/send: bus reset steps 00/01
// - release/send: reset after transfer, step 02
// - release/send: timeout gives 2Ch/01h
// - release: attention after message-in, step 01
// - release/send complete with 60h/02h
// - send: attention gives 61h or 62h, 02h
// - send with zero count refused, 65h/01h
// -----------------------------------------------------------------
`timescale 1ns/1ps
module stcr_core
	import stcr_pkg::*;
(
	input  wire logic                  clock_i,
	input  wire logic                  rst_i,
	input  wire logic                  cmd_valid_i,
	input  stcr_pkg::stcr_cmd_type     cmd_i,
	input  wire logic [7:0]            msg_count_i,
	input  wire logic                  bus_reset_i,
	input  wire logic                  atn_i,
	input  wire logic                  phase_done_i,
	input  wire logic                  timeout_i,
	input  wire logic                  msg_rcvd_i,
	input  wire logic                  report_take_i,
	output logic                       cmd_ready_o,
	output logic                       phase_run_o,
	output stcr_pkg::stcr_phase_type   phase_sel_o,
	output logic                       report_valid_o,
	output stcr_pkg::stcr_report_type  report_o
);

	// -----------------------------------------------------------------
	// state
	// -----------------------------------------------------------------
	typedef enum logic [6:0] {
		ST_IDLE   = 7'h01,
		ST_PRE    = 7'h02,
		ST_STATUS = 7'h04,
		ST_MSGIN  = 7'h08,
		ST_XFER   = 7'h10,
		ST_GAP    = 7'h20,
		ST_RX     = 7'h40
	} stcr_state_type;

	stcr_state_type  state;
	stcr_state_type  next_state;
	stcr_cmd_type    cmd;
	stcr_cmd_type    next_cmd;
	logic [7:0]      step;
	logic [7:0]      next_step;
	logic            next_ready;
	logic            next_run;
	stcr_phase_type  next_sel;
	logic            rpt_load;
	stcr_report_type rpt_data;
	logic [SYNC_WIDTH-1:0] pins_sync;
	logic            bus_rst;
	logic            atn;
	logic            is_close;
	logic            is_final;
	logic [7:0]      final_step;

	// -----------------------------------------------------------------
	// bus-side levels come from another timing world
	// -----------------------------------------------------------------
	stcr_sync u_sync (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.async_i ({atn_i, bus_reset_i}),
		.sync_o  (pins_sync)
	);

	assign bus_rst    = pins_sync[SYNC_BUS_RESET];
	assign atn        = pins_sync[SYNC_ATN];
	assign is_close   = (cmd.kind == CMD_CLOSE) || (cmd.kind == CMD_LINK);
	assign final_step = is_close ? STEP_CLOSE_AFTER : STEP_XFER_AFTER;
	assign is_final   = (step == final_step);

	// attention report; the linked and send ends use their own codes
	function automatic stcr_report_type atn_report(
		input stcr_cmd_kind_type kind,
		input logic              fin,
		input logic [7:0]        cur_step,
		input logic              received
	);
		stcr_report_type r;
		r.code = received ? CODE_ATN_RX : CODE_ATN;
		r.step = fin ? cur_step - STEP_ONE : cur_step;
		if (fin && (kind == CMD_LINK || kind == CMD_SEND)) begin
			r.code = received ? CODE_DONE_ATN_RX : CODE_DONE_ATN;
			r.step = cur_step;
		end
		return r;
	endfunction : atn_report

	// -----------------------------------------------------------------
	// sequence control
	// -----------------------------------------------------------------
	always_comb begin
		next_state = state;
		next_cmd   = cmd;
		next_step  = step;
		rpt_load   = 1'b0;
		rpt_data   = '0;
		unique case (state)
			ST_IDLE: begin
				if (cmd_valid_i && cmd_ready_o) begin
					next_cmd  = cmd_i;
					next_step = STEP_PRE;
					if (cmd_i.kind == CMD_SEND && msg_count_i == MSG_COUNT_EMPTY) begin
						rpt_load      = 1'b1;
						rpt_data.code = CODE_NO_COUNT;
						rpt_data.step = STEP_NO_COUNT;
					end else begin
						next_state = ST_PRE;
					end
				end
			end
			ST_PRE: begin
				if (bus_rst) begin
					rpt_load      = 1'b1;
					rpt_data.code = CODE_BUS_RESET;
					rpt_data.step = step;
					next_state    = ST_IDLE;
				end else begin
					next_state = is_close ? ST_STATUS : ST_XFER;
					next_step  = STEP_FIRST;
				end
			end
			ST_STATUS, ST_MSGIN, ST_XFER: begin
				if (bus_rst) begin
					rpt_load      = 1'b1;
					rpt_data.code = CODE_BUS_RESET;
					rpt_data.step = step;
					next_state    = ST_IDLE;
				end else if (timeout_i) begin
					rpt_load      = 1'b1;
					rpt_data.code = (state == ST_MSGIN) ? CODE_TIMEOUT_MSG : CODE_TIMEOUT;
					rpt_data.step = step;
					next_state    = ST_IDLE;
				end else if (phase_done_i) begin
					next_state = ST_GAP;
					if (state != ST_STATUS) begin
						next_step = step + STEP_ONE;
					end
				end
			end
			ST_GAP: begin
				if (bus_rst) begin
					rpt_load      = 1'b1;
					rpt_data.code = CODE_BUS_RESET;
					rpt_data.step = step;
					next_state    = ST_IDLE;
				end else if (atn) begin
					if (cmd.auto_rx) begin
						next_state = ST_RX;
					end else begin
						rpt_load   = 1'b1;
						rpt_data   = atn_report(cmd.kind, is_final, step, 1'b0);
						next_state = ST_IDLE;
					end
				end else if (is_final) begin
					rpt_load      = 1'b1;
					rpt_data.code = CODE_DONE;
					rpt_data.step = step;
					next_state    = ST_IDLE;
				end else begin
					next_state = ST_MSGIN;
					next_step  = STEP_MSGIN;
				end
			end
			ST_RX: begin
				if (bus_rst) begin
					rpt_load      = 1'b1;
					rpt_data.code = CODE_BUS_RESET;
					rpt_data.step = step;
					next_state    = ST_IDLE;
				end else if (timeout_i) begin
					rpt_load      = 1'b1;
					rpt_data.code = CODE_TIMEOUT;
					rpt_data.step = STEP_FIRST;
					next_state    = ST_IDLE;
				end else if (msg_rcvd_i) begin
					rpt_load   = 1'b1;
					rpt_data   = atn_report(cmd.kind, is_final, step, 1'b1);
					next_state = ST_IDLE;
				end
			end
			default: begin
				next_state = ST_IDLE;
			end
		endcase
	end

	// -----------------------------------------------------------------
	// phase request and readiness, registered so the ports are clean
	// -----------------------------------------------------------------
	always_comb begin
		next_run = 1'b0;
		next_sel = PH_STATUS;
		unique case (next_state)
			ST_STATUS: begin
				next_run = 1'b1;
				next_sel = PH_STATUS;
			end
			ST_MSGIN, ST_XFER: begin
				next_run = 1'b1;
				next_sel = PH_MSGIN;
			end
			ST_RX: begin
				next_run = 1'b1;
				next_sel = PH_MSGOUT;
			end
			default: begin
				next_run = 1'b0;
				next_sel = PH_STATUS;
			end
		endcase
		// a new command waits until the last report has been taken
		next_ready = (next_state == ST_IDLE) && !rpt_load &&
			!(report_valid_o && !report_take_i);
	end

	always_ff @(posedge clock_i or posedge rst_i) begin
		if (rst_i) begin
			state       <= ST_IDLE;
			cmd         <= '{kind: CMD_CLOSE, auto_rx: 1'b0};
			step        <= STEP_PRE;
			cmd_ready_o <= 1'b0;
			phase_run_o <= 1'b0;
			phase_sel_o <= PH_STATUS;
		end else begin
			state       <= next_state;
			cmd         <= next_cmd;
			step        <= next_step;
			cmd_ready_o <= next_ready;
			phase_run_o <= next_run;
			phase_sel_o <= next_sel;
		end
	end

	// -----------------------------------------------------------------
	// report holder
	// -----------------------------------------------------------------
	stcr_report u_report (
		.clock_i (clock_i),
		.rst_i   (rst_i),
		.load_i  (rpt_load),
		.data_i  (rpt_data),
		.take_i  (report_take_i),
		.valid_o (report_valid_o),
		.data_o  (report_o)
	);

	// -----------------------------------------------------------------
	// checks
	// -----------------------------------------------------------------
	default clocking cb @(posedge clock_i); endclocking
	default disable iff (rst_i);

	a_zero_count_refuse: assert property (
		(state == ST_IDLE && cmd_valid_i && cmd_ready_o && cmd_i.kind == CMD_SEND &&
			msg_count_i == MSG_COUNT_EMPTY)
		|=> report_valid_o && report_o.code == 8'h65 && report_o.step == 8'h01 && !phase_run_o [*2])
		else $error("zero count send not refused");

	a_reset_stops_phase: assert property (
		(phase_run_o && state != ST_GAP && bus_rst)
		|=> !phase_run_o && report_valid_o && report_o.code == 8'h01)
		else $error("bus reset did not end the phase");

	a_status_timeout: assert property (
		(state == ST_STATUS && !bus_rst && timeout_i)
		|=> report_o.code == 8'h2c && report_o.step == 8'h01 && state == ST_IDLE)
		else $error("status timeout report wrong");

	a_msgin_timeout: assert property (
		(state == ST_MSGIN && !bus_rst && timeout_i)
		|=> report_o.code == 8'h20 && report_o.step == 8'h02)
		else $error("message-in timeout report wrong");

	a_close_complete: assert property (
		(state == ST_GAP && is_close && step == 8'h03 && !bus_rst && !atn)
		|=> report_valid_o && report_o.code == 8'h60 && report_o.step == 8'h03)
		else $error("close completion report wrong");

	a_xfer_complete: assert property (
		(state == ST_GAP && !is_close && step == 8'h02 && !bus_rst && !atn)
		|=> report_o.code == 8'h60 && report_o.step == 8'h02)
		else $error("transfer completion report wrong");

	a_report_hold: assert property (
		(report_valid_o && !report_take_i && !rpt_load)
		|=> report_valid_o && $stable(report_o))
		else $error("report dropped before taken");

	a_auto_rx_phase: assert property (
		(state == ST_GAP && !bus_rst && atn && cmd.auto_rx)
		|=> phase_run_o && phase_sel_o == PH_MSGOUT && !report_valid_o ##0 state == ST_RX)
		else $error("auto receive did not start");

	a_pre_reset_step: assert property (
		(state == ST_PRE && bus_rst)
		|=> report_o.code == 8'h01 && report_o.step == 8'h00 && !phase_run_o)
		else $error("reset before transfer report wrong");

	a_step_advance: assert property (
		(state == ST_MSGIN && !bus_rst && !timeout_i && phase_done_i)
		|=> state == ST_GAP && step == 8'h03 ##1 (state != ST_GAP || step == 8'h03))
		else $error("step did not advance after message-in");

endmodule : stcr_core

// ==== tb/stcr_initiator_model.sv ====
// initiator and transfer engine model facing the reporter
`timescale 1ns/1ps
module stcr_initiator_model
	import stcr_pkg::*;
(
	input  wire logic                 clock_i,
	input  wire logic                 rst_i,
	input  wire logic                 clear_i,
	input  wire logic                 phase_run_i,
	input  stcr_pkg::stcr_phase_type  phase_sel_i,
	input  wire logic [1:0]           fail_at_i,
	input  wire logic [1:0]           atn_at_i,
	input  wire logic [2:0]           rst_at_i,
	input  wire logic [3:0]           stall_i,
	output logic                      phase_done_o,
	output logic                      timeout_o,
	output logic                      msg_rcvd_o,
	output logic                      atn_o,
	output logic                      bus_reset_o
);
	logic       run_q;
	logic [1:0] pnum;
	logic [3:0] cnt;

	// ---------------------------------------------
	// phase engine
	// ---------------------------------------------
	// levels rise as a phase opens so the two-flop sync settles well before the
	// phase ends; pulses span one falling edge to the next, seen once
	always @(negedge clock_i or posedge rst_i) begin
		if (rst_i || clear_i) begin
			phase_done_o <= 1'b0;
			timeout_o    <= 1'b0;
			msg_rcvd_o   <= 1'b0;
			atn_o        <= 1'b0;
			bus_reset_o  <= 1'b0;
			run_q        <= 1'b0;
			pnum         <= 2'd0;
			cnt          <= 4'd0;
		end else begin
			phase_done_o <= 1'b0;
			timeout_o    <= 1'b0;
			msg_rcvd_o   <= 1'b0;
			run_q        <= phase_run_i;
			// 4: reset already standing when the command arrives
			if (rst_at_i == 3'd4) bus_reset_o <= 1'b1;
			if (phase_run_i && !run_q) begin
				cnt <= 4'd0;
				if (phase_sel_i != PH_MSGOUT) begin
					pnum <= pnum + 2'd1;
					if (atn_at_i == pnum + 2'd1) atn_o <= 1'b1;
					if (rst_at_i == {1'b0, pnum + 2'd1}) bus_reset_o <= 1'b1;
				end
			end else if (phase_run_i) begin
				cnt <= cnt + 4'd1;
				// raised one edge ahead of the phase end so the sync lets only the gap see it
				if (phase_sel_i != PH_MSGOUT && rst_at_i == {1'b1, pnum} && cnt == stall_i - 4'd1) bus_reset_o <= 1'b1;
				if (cnt == stall_i) begin
					if (phase_sel_i == PH_MSGOUT) msg_rcvd_o <= 1'b1;
					else if (fail_at_i == pnum) timeout_o <= 1'b1;
					else phase_done_o <= 1'b1;
				end
			end
		end
	end
endmodule : stcr_initiator_model

// ==== tb/stcr_core_tb.sv ====
// self-checking bench for the target completion reporter
`timescale 1ns/1ps
module stcr_core_tb;
	import stcr_pkg::*;
	logic              clock_i       = 1'b0;
	logic              rst_i         = 1'b1;
	logic              cmd_valid_i   = 1'b0;
	logic              report_take_i = 1'b0;
	logic              clear         = 1'b1;
	stcr_cmd_type      cmd_i         = '0;
	logic [7:0]        msg_count_i   = 8'h00;
	logic [1:0]        fail_at       = 2'd0;
	logic [1:0]        atn_at        = 2'd0;
	logic [2:0]        rst_at        = 3'd0;
	logic [3:0]        stall         = 4'd3;
	logic [31:0]       seed          = 32'h81cd;
	logic              bus_reset_i, atn_i, phase_done_i, timeout_i, msg_rcvd_i;
	logic              cmd_ready_o, phase_run_o, report_valid_o;
	stcr_phase_type    phase_sel_o;
	stcr_report_type   report_o;
	int                bad_count     = 0;
	int                tests_run     = 0;
	int                cycles        = 0;

	always #20 clock_i = ~clock_i;

	stcr_core u_stcr_core (.clock_i(clock_i), .rst_i(rst_i), .cmd_valid_i(cmd_valid_i), .cmd_i(cmd_i),
		.msg_count_i(msg_count_i), .bus_reset_i(bus_reset_i), .atn_i(atn_i), .phase_done_i(phase_done_i),
		.timeout_i(timeout_i), .msg_rcvd_i(msg_rcvd_i), .report_take_i(report_take_i),
		.cmd_ready_o(cmd_ready_o), .phase_run_o(phase_run_o), .phase_sel_o(phase_sel_o),
		.report_valid_o(report_valid_o), .report_o(report_o));

	stcr_initiator_model u_stcr_initiator_model (.clock_i(clock_i), .rst_i(rst_i), .clear_i(clear),
		.phase_run_i(phase_run_o), .phase_sel_i(phase_sel_o), .fail_at_i(fail_at), .atn_at_i(atn_at),
		.rst_at_i(rst_at), .stall_i(stall), .phase_done_o(phase_done_i), .timeout_o(timeout_i),
		.msg_rcvd_o(msg_rcvd_i), .atn_o(atn_i), .bus_reset_o(bus_reset_i));

	// ---------------------------------------------
	// helpers
	// ---------------------------------------------
	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
	endfunction : lfsr

	// ev: 0 normal, 1 timeout in phase at, 2 attention after phase at,
	// 3 bus reset: at 0 before the transfer, 1 or 2 in that phase, 3 after the last phase
	function automatic stcr_report_type expect_report(input logic [1:0] kind, input logic auto,
		input logic [1:0] ev, input logic [1:0] at, input logic [7:0] count);
		if (kind == 2'd3 && count == 8'h00) return '{8'h65, 8'h01};
		case (ev)
			2'd1: return (at == 2'd2) ? '{8'h20, 8'h02} : '{8'h2c, 8'h01};
			2'd3: return '{8'h01, (at == 2'd3) ? ((kind <= 2'd1) ? 8'h03 : 8'h02) : {6'h00, at}};
			2'd2: begin
				if (kind == 2'd1 && at == 2'd2) return '{auto ? 8'h62 : 8'h61, 8'h03};
				if (kind == 2'd3) return '{auto ? 8'h62 : 8'h61, 8'h02};
				return '{auto ? 8'h43 : 8'h42, {6'h00, at}};
			end
			default: return '{8'h60, (kind <= 2'd1) ? 8'h03 : 8'h02};
		endcase
	endfunction : expect_report

	task automatic compare_report(input string name, input stcr_report_type exp, input stcr_report_type got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %h seen %h", name, exp, got);
		end
	endtask : compare_report

	task automatic compare_bit(input string name, input logic exp, input logic got);
		tests_run++;
		if (got !== exp) begin
			bad_count++;
			$display("[ERR] %s expected %b seen %b", name, exp, got);
		end
	endtask : compare_bit

	task automatic end_of_test();
		if (bad_count == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask : end_of_test

	// one command from issue to taken report; a stray request while busy must be ignored
	task automatic run_case(input logic [1:0] kind, input logic auto, input logic [1:0] ev,
		input logic [1:0] at, input logic [7:0] count);
		stcr_report_type exp;
		int              n;
		logic            run1;
		exp = expect_report(kind, auto, ev, at, count);
		n = 0;
		while (cmd_ready_o !== 1'b1 && n < 50) begin
			@(negedge clock_i);
			n++;
		end
		compare_bit("ready_wait", 1'b1, cmd_ready_o);
		seed = lfsr(seed);
		clear = 1'b0;
		fail_at = (ev == 2'd1) ? at : 2'd0;
		atn_at = (ev == 2'd2) ? at : 2'd0;
		rst_at = (ev != 2'd3) ? 3'd0 :
			(at == 2'd0) ? 3'd4 :
			(at == 2'd3) ? {1'b1, (kind < 2'd2) ? 2'd2 : 2'd1} :
			{1'b0, at};
		stall = 4'd3 + {1'b0, seed[2:0]};
		// two edges of lead so a reset standing before the command is seen through the sync
		repeat (2) @(negedge clock_i);
		cmd_i = '{stcr_cmd_kind_type'(kind), auto};
		msg_count_i = count;
		cmd_valid_i = 1'b1;
		@(negedge clock_i);
		compare_bit("busy", 1'b0, cmd_ready_o);
		cmd_valid_i = seed[3];
		cmd_i = '{stcr_cmd_kind_type'(kind ^ 2'd1), ~auto};
		@(negedge clock_i);
		cmd_valid_i = 1'b0;
		run1 = (kind != 2'd3 || count != 8'h00) && !(ev == 2'd3 && at == 2'd0);
		compare_bit("first_run", run1, phase_run_o);
		if (run1) compare_bit("first_sel", 1'b1, phase_sel_o == ((kind < 2'd2) ? PH_STATUS : PH_MSGIN));
		n = 0;
		while (report_valid_o !== 1'b1 && n < 200) begin
			@(negedge clock_i);
			n++;
		end
		compare_bit("report_wait", 1'b1, report_valid_o);
		compare_report("report", exp, report_o);
		compare_bit("run_idle", 1'b0, phase_run_o);
		clear = 1'b1;
		repeat (3) @(negedge clock_i);
		compare_bit("held_valid", 1'b1, report_valid_o);
		compare_report("held_report", exp, report_o);
		report_take_i = 1'b1;
		@(negedge clock_i);
		report_take_i = 1'b0;
		@(negedge clock_i);
		compare_bit("taken", 1'b0, report_valid_o);
		compare_bit("ready_again", 1'b1, cmd_ready_o);
		repeat (3) @(negedge clock_i);
	endtask : run_case

	// ---------------------------------------------
	// sequence
	// ---------------------------------------------
	always @(posedge clock_i) begin
		cycles++;
		if (cycles == 20000) begin
			bad_count++;
			end_of_test();
		end
	end

	initial begin
		repeat (20) @(negedge clock_i);
		rst_i = 1'b0;
		repeat (2) @(negedge clock_i);
		for (int k = 0; k < 4; k++) begin
			for (int a = 0; a < 2; a++) begin
				for (int e = 0; e < 4; e++) begin
					for (int p = 1; p < 3; p++) begin
						seed = lfsr(seed);
						if (p == 1 || k < 2) begin
							run_case(k[1:0], a[0], e[1:0], p[1:0], seed[7:0] | 8'h01);
						end
					end
				end
			end
		end
		for (int a = 0; a < 2; a++) begin
			run_case(2'd3, a[0], 2'd2, 2'd1, 8'h00);
			run_case(2'd3, a[0], 2'd0, 2'd1, 8'hff);
		end
		for (int k = 0; k < 4; k++) begin
			run_case(k[1:0], k[0], 2'd3, 2'd0, 8'h01);
			run_case(k[1:0], k[1], 2'd3, 2'd3, 8'h01);
		end
		repeat (24) begin
			seed = lfsr(seed);
			run_case(seed[1:0], seed[2], seed[4:3], (!seed[1] && seed[5]) ? 2'd2 : 2'd1, seed[15:8]);
		end
		// reset in mid-phase: outputs fall at once, block comes back idle with no report
		clear = 1'b0;
		fail_at = 2'd0;
		atn_at = 2'd0;
		rst_at = 3'd0;
		stall = 4'd10;
		cmd_i = '{CMD_CLOSE, 1'b0};
		msg_count_i = 8'h01;
		cmd_valid_i = 1'b1;
		@(negedge clock_i);
		cmd_valid_i = 1'b0;
		repeat (3) @(negedge clock_i);
		compare_bit("mid_run", 1'b1, phase_run_o);
		rst_i = 1'b1;
		@(negedge clock_i);
		compare_bit("rst_ready", 1'b0, cmd_ready_o);
		compare_bit("rst_run", 1'b0, phase_run_o);
		repeat (2) @(negedge clock_i);
		rst_i = 1'b0;
		clear = 1'b1;
		@(negedge clock_i);
		compare_bit("rst_idle", 1'b1, cmd_ready_o);
		compare_bit("rst_report", 1'b0, report_valid_o);
		end_of_test();
	end
endmodule : stcr_core_tb
